// ===== hw/codec_consts.svh
// Purpose: shared constants of the codec serial request decoder
// Assumes: included by bare name
// Notes: timing counts are in master-clock (ref_clk) periods
//
// Overview of operation
// [R1] primary control bits 11 ask for a further 16-bit secondary control word
// [R2] primary phase shift may come from pins or bits while the other reads 11 or 00
// [R3] pins and bits both asking a shift in a primary word: the bits win
// [R4] secondary request from one source and shift from the other both act
// [R5] primary bits not 11: pins at 11 ask for a secondary frame
// [R6] in a secondary word pins count only when secondary bits are 11
// [R7] code 01 asks a later sample, 10 an earlier one, for every source
// [R8] secondary bits 00 give no shift even when pins ask one
// [R9] a secondary word never starts a further secondary frame
// [R10] read/write bit 0: all sixteen secondary output bits are zero
// [R11] read/write bit 1: upper eight zero, lower eight carry register data
// [R12] primary frame: 14-bit value plus two bits in, 14-bit result with two zero lsbs out
// [R13] secondary starts half a period after primary, half a filter clock earlier if odd
// [R14] master drives secondary sync low on first shift rise after half count
// [R15] slave and codec modes: host makes frame sync and shift clock
// [R16] codec mode: host holds each sync low at least one shift clock
// [R17] slave modes: host leaves time to prepare the secondary word
// [R18] conversion results are two's complement about the mid reference
// [R19] shift request latched at next internal frame sync, used one period only
// [R20] secondary control word takes effect on the sixteenth falling shift edge
// [R21] earlier or later changes the next period by the signed offset in mclks
`ifndef CODEC_CONSTS_SVH
`define CODEC_CONSTS_SVH

`define CSR_WORD_BITS 16
`define CSR_DAC_BITS 14
`define CSR_PIN_COUNT 5
`define CSR_PIN_SCLK 0
`define CSR_PIN_FSYNC 1
`define CSR_PIN_DIN 2
`define CSR_PIN_REQ_HI 3
`define CSR_PIN_REQ_LO 4
`define CSR_PRI_CTRL_HI 1
`define CSR_PRI_CTRL_LO 0
`define CSR_SEC_CTRL_HI 15
`define CSR_SEC_CTRL_LO 14
`define CSR_SEC_RW_BIT 13
`define CSR_SEC_ADDR_BITS 5
`define CSR_LAST_BIT 15
`define CSR_ADDR_DONE_BIT 7
`define CSR_READ_SLOT 8
`define CSR_SCLK_HALF_DEF 4

`endif

// ===== hw/codec_pkg.sv
// Purpose: types of the codec serial request decoder
// Assumes: nothing
// Notes: constants live in codec_consts.svh
package codec_pkg;
    typedef logic [1:0] ctrl_pair_type;

    typedef enum logic [2:0]
    {
        LN_IDLE = 3'h1,
        LN_ARMED = 3'h2,
        LN_DRIVE = 3'h4
    } launch_state_type;
endpackage

// ===== hw/codec_decode_if.sv
// Purpose: carrier between the frame engine and the request decoder
// Assumes: single ref_clk domain
// Notes: purely combinational signals
`timescale 1ns/1ps
interface codec_decode_if;
    logic is_secondary;
    codec_pkg::ctrl_pair_type ctrl;
    codec_pkg::ctrl_pair_type pins;
    logic earlier;
    logic later;
    logic sec_req;

    modport engine (output is_secondary, output ctrl, output pins,
                    input earlier, input later, input sec_req);
    modport decoder (input is_secondary, input ctrl, input pins,
                     output earlier, output later, output sec_req);
endinterface

// ===== hw/codec_request_decode.sv
// Purpose: truth table for secondary and phase-shift requests
// Assumes: ctrl and pins stable while evaluated
// Notes: codes 01 later, 10 earlier, 11 secondary / defer
`timescale 1ns/1ps
module codec_request_decode
(
    codec_decode_if.decoder dif
);
    always_comb
    begin
        dif.earlier = 1'b0;
        dif.later = 1'b0;
        dif.sec_req = 1'b0;
        if (dif.is_secondary)
        begin
            // no secondary request from inside a secondary word
            dif.sec_req = 1'b0; // [R9]
            case (dif.ctrl)
                2'h1: dif.later = 1'b1; // [R7]
                2'h2: dif.earlier = 1'b1; // [R7]
                2'h3:
                begin
                    dif.later = (dif.pins == 2'h1); // [R6]
                    dif.earlier = (dif.pins == 2'h2); // [R6]
                end
                default: ; // [R8]
            endcase
        end
        else
        begin
            dif.sec_req = (dif.ctrl == 2'h3) || (dif.pins == 2'h3); // [R1] [R5] [R4]
            case (dif.ctrl)
                2'h1: dif.later = 1'b1; // [R3] [R7]
                2'h2: dif.earlier = 1'b1; // [R3] [R7]
                default:
                begin
                    dif.later = (dif.pins == 2'h1); // [R2]
                    dif.earlier = (dif.pins == 2'h2); // [R2]
                end
            endcase
        end
    end
endmodule

// ===== hw/codec_serial_request_decoder.sv
// Purpose: serial frame engine and request logic of the codec
// Assumes: ref_clk is the master clock; pin inputs are asynchronous
// Notes: master_mode high makes shift clock and frame sync here
`timescale 1ns/1ps
`include "codec_consts.svh"
module codec_serial_request_decoder
#(
    parameter int SCLK_HALF = `CSR_SCLK_HALF_DEF
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic master_mode,
    input wire logic [7:0] a_div,
    input wire logic [7:0] b_div,
    input wire logic [7:0] a_prime,
    input wire logic [13:0] adc_sample,
    input wire logic [7:0] reg_rd_data,
    input wire logic shift_clk_in,
    input wire logic frame_sync_in_n,
    input wire logic serial_data_in,
    input wire logic hw_request_pin_hi,
    input wire logic hw_request_pin_lo,
    output logic shift_clk_out,
    output logic frame_sync_out_n,
    output logic serial_data_out,
    output logic [13:0] dac_data,
    output logic dac_valid,
    output logic [15:0] ctrl_word,
    output logic ctrl_valid,
    output logic [4:0] reg_addr,
    output logic sample_strobe,
    output logic phase_earlier,
    output logic phase_later,
    output logic secondary_pending
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers

    logic [`CSR_PIN_COUNT-1:0] pin_raw;
    logic [`CSR_PIN_COUNT-1:0] sync1_r;
    logic [`CSR_PIN_COUNT-1:0] sync2_r;
    logic [`CSR_PIN_COUNT-1:0] sync3_r;
    logic [`CSR_PIN_COUNT-1:0] filt_r;

    assign pin_raw = {hw_request_pin_lo, hw_request_pin_hi, serial_data_in,
                      frame_sync_in_n, shift_clk_in};

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            sync1_r <= '1;
            sync2_r <= '1;
            sync3_r <= '1;
        end
        else if (clk_en)
        begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // a change counts once stages two and three agree
    for (genvar i = 0; i < `CSR_PIN_COUNT; i++)
    begin : g_filt
        always_ff @(posedge ref_clk)
        begin
            if (!rst_n)
                filt_r[i] <= 1'b1;
            else if (clk_en && (sync2_r[i] == sync3_r[i]))
                filt_r[i] <= sync3_r[i];
        end
    end

////////////////////////////////////////////////////////////////////////////////
// shift clock generation and edge events

    logic [7:0] div_cnt_r;
    logic sclk_r;
    logic sclk_prev_r;
    logic m_rise;
    logic m_fall;
    logic rise_ev;
    logic fall_ev;
    logic fs_low;
    logic fsync_r;

    assign m_rise = (div_cnt_r == 8'(SCLK_HALF - 1)) && !sclk_r;
    assign m_fall = (div_cnt_r == 8'(SCLK_HALF - 1)) && sclk_r;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            div_cnt_r <= 8'h00;
            sclk_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (div_cnt_r == 8'(SCLK_HALF - 1))
            begin
                div_cnt_r <= 8'h00;
                sclk_r <= !sclk_r;
            end
            else
                div_cnt_r <= div_cnt_r + 8'h01;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            sclk_prev_r <= 1'b1;
        else if (clk_en)
            sclk_prev_r <= filt_r[`CSR_PIN_SCLK];
    end

    // slave and codec modes follow the host's sync and clock
    assign rise_ev = master_mode ? m_rise
                                 : (filt_r[`CSR_PIN_SCLK] && !sclk_prev_r); // [R15]
    assign fall_ev = master_mode ? m_fall
                                 : (!filt_r[`CSR_PIN_SCLK] && sclk_prev_r); // [R15]
    // a codec-mode sync held one shift clock is seen at a rise
    assign fs_low = master_mode ? !fsync_r : !filt_r[`CSR_PIN_FSYNC]; // [R16]

////////////////////////////////////////////////////////////////////////////////
// sampling period and filter clock timing

    logic [19:0] per_cnt_r;
    logic [19:0] base_len;
    logic [19:0] offset;
    logic [19:0] next_len;
    logic [8:0] flt_cnt_r;
    logic [7:0] b_cnt_r;
    logic per_tick;
    logic flt_tick;
    logic half_hit;
    logic [1:0] pend_r;

    assign per_tick = (per_cnt_r == 20'h00000);
    assign base_len = 20'(a_div) * 20'(b_div) * 20'h00002;
    assign offset = {{12{a_prime[7]}}, a_prime};

    always_comb
    begin
        next_len = base_len;
        if (pend_r[1])
            next_len = base_len - offset; // [R21]
        else if (pend_r[0])
            next_len = base_len + offset; // [R21]
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            per_cnt_r <= 20'h00000;
        else if (clk_en)
        begin
            if (per_tick)
                per_cnt_r <= next_len - 20'h00001;
            else
                per_cnt_r <= per_cnt_r - 20'h00001;
        end
    end

    assign flt_tick = (flt_cnt_r >= ({1'b0, a_div} << 1) - 9'h001);
    // floor(b/2): half period when even, half a filter clock less when odd
    assign half_hit = flt_tick && ((b_cnt_r + 8'h01) == (b_div >> 1)); // [R13]

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            flt_cnt_r <= 9'h000;
            b_cnt_r <= 8'h00;
        end
        else if (clk_en)
        begin
            if (per_tick || flt_tick)
                flt_cnt_r <= 9'h000;
            else
                flt_cnt_r <= flt_cnt_r + 9'h001;
            if (per_tick)
                b_cnt_r <= 8'h00;
            else if (flt_tick)
                b_cnt_r <= b_cnt_r + 8'h01;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// master-mode frame sync launcher

    codec_pkg::launch_state_type ln_state_r;
    logic next_sec_r;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            ln_state_r <= codec_pkg::LN_IDLE;
            fsync_r <= 1'b1;
        end
        else if (clk_en)
        begin
            case (ln_state_r)
                codec_pkg::LN_IDLE:
                    if (master_mode && (per_tick || (half_hit && next_sec_r))) // [R13]
                        ln_state_r <= codec_pkg::LN_ARMED;
                codec_pkg::LN_ARMED:
                    if (m_rise)
                    begin
                        fsync_r <= 1'b0; // [R14]
                        ln_state_r <= codec_pkg::LN_DRIVE;
                    end
                codec_pkg::LN_DRIVE:
                    if (m_rise)
                    begin
                        fsync_r <= 1'b1;
                        ln_state_r <= codec_pkg::LN_IDLE;
                    end
                default:
                begin
                    fsync_r <= 1'b1;
                    ln_state_r <= codec_pkg::LN_IDLE;
                end
            endcase
        end
    end

////////////////////////////////////////////////////////////////////////////////
// serial frame engine

    logic active_r;
    logic [4:0] bit_cnt_r;
    logic [15:0] sout_r;
    logic [15:0] sin_r;
    logic [15:0] sin_nxt;
    logic [15:0] word_r;
    logic frame_sec_r;
    logic rw_r;
    logic done_r;
    logic [4:0] reg_addr_r;

    assign sin_nxt = {sin_r[14:0], filt_r[`CSR_PIN_DIN]};

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            active_r <= 1'b0;
            bit_cnt_r <= 5'h00;
            sout_r <= 16'h0000;
            sin_r <= 16'h0000;
            word_r <= 16'h0000;
            frame_sec_r <= 1'b0;
            rw_r <= 1'b0;
            done_r <= 1'b0;
            reg_addr_r <= 5'h00;
        end
        else if (clk_en)
        begin
            done_r <= 1'b0;
            if (rise_ev && !active_r && fs_low)
            begin
                active_r <= 1'b1;
                bit_cnt_r <= 5'h00;
                frame_sec_r <= next_sec_r;
                rw_r <= 1'b0;
                if (next_sec_r)
                    sout_r <= 16'h0000; // [R10]
                else
                    sout_r <= {adc_sample, 2'h0}; // [R12] [R18]
            end
            else if (rise_ev && active_r && (bit_cnt_r != 5'h00))
            begin
                if (frame_sec_r && (bit_cnt_r == 5'(`CSR_READ_SLOT)))
                    sout_r <= {(rw_r ? reg_rd_data : 8'h00), 8'h00}; // [R10] [R11]
                else
                    sout_r <= {sout_r[14:0], 1'b0};
            end
            if (fall_ev && active_r)
            begin
                sin_r <= sin_nxt;
                bit_cnt_r <= bit_cnt_r + 5'h01;
                if (bit_cnt_r == 5'(`CSR_ADDR_DONE_BIT))
                begin
                    rw_r <= sin_nxt[`CSR_SEC_RW_BIT - 8];
                    reg_addr_r <= sin_nxt[`CSR_SEC_ADDR_BITS-1:0];
                end
                if (bit_cnt_r == 5'(`CSR_LAST_BIT))
                begin
                    active_r <= 1'b0;
                    done_r <= 1'b1; // [R20]
                    word_r <= sin_nxt; // [R1]
                end
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// request decoding

    codec_decode_if dif ();

    assign dif.is_secondary = frame_sec_r;
    assign dif.ctrl = frame_sec_r ? word_r[`CSR_SEC_CTRL_HI:`CSR_SEC_CTRL_LO]
                                  : word_r[`CSR_PRI_CTRL_HI:`CSR_PRI_CTRL_LO];
    assign dif.pins = {filt_r[`CSR_PIN_REQ_HI], filt_r[`CSR_PIN_REQ_LO]};

    codec_request_decode u_decode
    (
        .dif(dif)
    );

    logic [13:0] dac_data_r;
    logic dac_valid_r;
    logic [15:0] ctrl_word_r;
    logic ctrl_valid_r;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            dac_data_r <= 14'h0000;
            dac_valid_r <= 1'b0;
            ctrl_word_r <= 16'h0000;
            ctrl_valid_r <= 1'b0;
        end
        else if (clk_en)
        begin
            dac_valid_r <= done_r && !frame_sec_r;
            ctrl_valid_r <= done_r && frame_sec_r;
            if (done_r && !frame_sec_r)
                dac_data_r <= word_r[15:2]; // [R12]
            if (done_r && frame_sec_r)
                ctrl_word_r <= word_r; // [R20]
        end
    end

    // pending secondary frame; the start of that frame consumes it
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            next_sec_r <= 1'b0;
        else if (clk_en)
        begin
            if (done_r && !frame_sec_r && dif.sec_req)
                next_sec_r <= 1'b1; // [R1] [R5]
            else if (rise_ev && !active_r && fs_low && next_sec_r)
                next_sec_r <= 1'b0; // [R9]
        end
    end

////////////////////////////////////////////////////////////////////////////////
// phase request latch

    logic phase_earlier_r;
    logic phase_later_r;
    logic sample_strobe_r;

    // a request arriving on the tick itself is kept for the next period
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            pend_r <= 2'h0;
            phase_earlier_r <= 1'b0;
            phase_later_r <= 1'b0;
            sample_strobe_r <= 1'b0;
        end
        else if (clk_en)
        begin
            sample_strobe_r <= per_tick;
            phase_earlier_r <= per_tick && pend_r[1]; // [R19]
            phase_later_r <= per_tick && pend_r[0] && !pend_r[1]; // [R19]
            if (done_r && (dif.earlier || dif.later))
                pend_r <= {dif.earlier, dif.later}; // [R4] [R19]
            else if (per_tick)
                pend_r <= 2'h0; // [R19]
        end
    end

////////////////////////////////////////////////////////////////////////////////
// outputs

    assign shift_clk_out = sclk_r;
    assign frame_sync_out_n = fsync_r;
    assign serial_data_out = sout_r[15];
    assign dac_data = dac_data_r;
    assign dac_valid = dac_valid_r;
    assign ctrl_word = ctrl_word_r;
    assign ctrl_valid = ctrl_valid_r;
    assign reg_addr = reg_addr_r;
    assign sample_strobe = sample_strobe_r;
    assign phase_earlier = phase_earlier_r;
    assign phase_later = phase_later_r;
    assign secondary_pending = next_sec_r;

endmodule

// ===== tb/codec_request_checker.sv
// Purpose: port-level timing checks of the request decoder
// Assumes: one ref_clk domain, clk_en held high
// Notes: bound from the testbench top file
`timescale 1ns/1ps
module codec_request_checker
#(
    parameter int SCLK_HALF = 4
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic master_mode,
    input wire logic [7:0] a_div,
    input wire logic [7:0] b_div,
    input wire logic [7:0] a_prime,
    input wire logic frame_sync_out_n,
    input wire logic shift_clk_out,
    input wire logic dac_valid,
    input wire logic ctrl_valid,
    input wire logic sample_strobe,
    input wire logic phase_earlier,
    input wire logic phase_later,
    input wire logic secondary_pending
);
    logic [15:0] cnt_r;
    logic seen_r;
    logic last_e_r;
    logic last_l_r;
    logic word_r;
    logic [17:0] exp_per;
    logic [17:0] sec_at;
    ////////////////////////////////////////////////////////////
    // cycles since the last period start, and its phase flags
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            cnt_r <= 16'h0;
            seen_r <= 1'h0;
            last_e_r <= 1'h0;
            last_l_r <= 1'h0;
        end
        else if (sample_strobe)
        begin
            cnt_r <= 16'h1;
            seen_r <= 1'h1;
            last_e_r <= phase_earlier;
            last_l_r <= phase_later;
        end
        else
            cnt_r <= cnt_r + 16'h1;
    end
    // a word has ended since the last period start
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            word_r <= 1'h0;
        else if (dac_valid || ctrl_valid)
            word_r <= 1'h1;
        else if (sample_strobe)
            word_r <= 1'h0;
    end
    assign exp_per = 18'h2 * a_div * b_div + (last_l_r ? 18'($signed(a_prime)) : 18'h0)
        - (last_e_r ? 18'($signed(a_prime)) : 18'h0);
    assign sec_at = 18'h2 * a_div * (b_div >> 1);
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    a_phase_on_strobe: assert property ((phase_earlier || phase_later) |-> sample_strobe)
        else $error("phase flag away from period start");
    a_phase_exclusive: assert property (!(phase_earlier && phase_later))
        else $error("earlier and later together");
    a_phase_once: assert property ($past(sample_strobe) && !$past(word_r)
        && !$past(dac_valid) && !$past(ctrl_valid) && !dac_valid && !ctrl_valid
        |-> !$past(phase_earlier) && !$past(phase_later))
        else $error("phase shift without a new request");
    a_period_len: assert property (sample_strobe && seen_r |-> cnt_r == exp_per)
        else $error("sampling period length wrong");
    a_sec_sync_time: assert property (master_mode && secondary_pending
        && $fell(frame_sync_out_n)
        |-> cnt_r >= sec_at && cnt_r <= sec_at + 18'(2 * SCLK_HALF + 3))
        else $error("secondary frame sync at wrong time");
    a_sync_on_rise: assert property ($fell(frame_sync_out_n) |-> $rose(shift_clk_out))
        else $error("frame sync not on a shift clock rise");
    a_slave_no_sync: assert property (!master_mode |-> frame_sync_out_n)
        else $error("frame sync driven in slave mode");
    a_no_resecondary: assert property (ctrl_valid |=> !secondary_pending [*2])
        else $error("secondary word left a secondary pending");
    a_pend_source: assert property ($rose(secondary_pending)
        |-> ##[0:4] $past(dac_valid, 2))
        else $error("secondary pending without a primary word");
    a_dac_pulse: assert property (dac_valid |-> !ctrl_valid ##1 !dac_valid)
        else $error("primary word valid not a single pulse");
    a_ctrl_pulse: assert property (ctrl_valid |=> !ctrl_valid)
        else $error("control word valid not a single pulse");
    c_primary: cover property (dac_valid && secondary_pending);
    c_secondary: cover property (ctrl_valid);
    c_earlier: cover property (phase_earlier);
    c_later: cover property (phase_later);
    c_sec_sync: cover property (master_mode && secondary_pending && $fell(frame_sync_out_n));
endmodule

// ===== tb/host_port_model.sv
// Purpose: host serial port making shift clock and frame sync
// Assumes: device in slave mode, HALF well above the pin sync delay
// Notes: shift clock stands low between frames
`timescale 1ns/1ps
module host_port_model
#(
    parameter int HALF = 10
)
(
    input wire logic ref_clk,
    input wire logic serial_data_out,
    output logic shift_clk_in,
    output logic frame_sync_in_n,
    output logic serial_data_in
);
    initial
    begin
        shift_clk_in = 1'h0;
        frame_sync_in_n = 1'h1;
        serial_data_in = 1'h0;
    end
    ////////////////////////////////////////////////////////////
    // one word msb first: data changes at rise, dout read at fall
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        @(posedge ref_clk);
        frame_sync_in_n <= 1'h0;
        serial_data_in <= tx[15];
        repeat (HALF) @(posedge ref_clk);
        for (int i = 15; i >= 0; i--)
        begin
            shift_clk_in <= 1'h1;
            serial_data_in <= tx[i];
            if (i == 14)
                frame_sync_in_n <= 1'h1;
            repeat (HALF) @(posedge ref_clk);
            shift_clk_in <= 1'h0;
            rx[i] = serial_data_out;
            // last low half cut short so the caller sees the word's valid pulse
            repeat ((i > 0) ? HALF : 2) @(posedge ref_clk);
        end
        // released line shows the inverse of the last bit
        serial_data_in <= ~tx[0];
    endtask
endmodule

// ===== tb/codec_serial_request_decoder_test.sv
// Purpose: self-checking bench of the codec serial request decoder
// Assumes: host_port_model drives the slave pins
// Notes: request tables walked in full, the rest from a fixed seed
`timescale 1ns/1ps
module codec_serial_request_decoder_test;
    localparam int SH = 2;
    logic ref_clk = 1'h0;
    logic rst_n = 1'h0;
    logic clk_en = 1'h1;
    logic master_mode = 1'h0;
    logic [7:0] a_div = 8'h4;
    logic [7:0] b_div = 8'h19;
    logic [7:0] a_prime = 8'h0;
    logic [13:0] adc_sample = 14'h0;
    logic [7:0] reg_rd_data = 8'h0;
    logic hw_request_pin_hi = 1'h0;
    logic hw_request_pin_lo = 1'h0;
    logic shift_clk_in, frame_sync_in_n, serial_data_in, shift_clk_out, frame_sync_out_n;
    logic serial_data_out, dac_valid, ctrl_valid, sample_strobe, phase_earlier, phase_later;
    logic secondary_pending;
    logic [13:0] dac_data;
    logic [15:0] ctrl_word;
    logic [4:0] reg_addr;
    logic [1:0] prev_ph = 2'h0;
    int bad_count = 0;
    int checked = 0;
    always #2.5 ref_clk = ~ref_clk;
    codec_serial_request_decoder #(.SCLK_HALF(SH)) codec_serial_request_decoder_i
    (
        .ref_clk, .rst_n, .clk_en, .master_mode, .a_div, .b_div, .a_prime, .adc_sample,
        .reg_rd_data, .shift_clk_in, .frame_sync_in_n, .serial_data_in, .hw_request_pin_hi,
        .hw_request_pin_lo, .shift_clk_out, .frame_sync_out_n, .serial_data_out, .dac_data,
        .dac_valid, .ctrl_word, .ctrl_valid, .reg_addr, .sample_strobe, .phase_earlier,
        .phase_later, .secondary_pending
    );
    host_port_model #(.HALF(10)) host_port_model_i
    (
        .ref_clk, .serial_data_out, .shift_clk_in, .frame_sync_in_n, .serial_data_in
    );
    ////////////////////////////////////////////////////////////
    function automatic logic [7:0] rd_model(input logic [4:0] addr);
        return {3'h5, addr};
    endfunction
    always @(posedge ref_clk)
        reg_rd_data <= rd_model(reg_addr);
    // expected {earlier, later, secondary request} of one word
    function automatic logic [2:0] expect_req(input logic sec, input logic [1:0] c,
        input logic [1:0] p);
        logic [1:0] sh;
        sh = 2'h0;
        if (c == 2'h1 || c == 2'h2)
            sh = c;
        else if ((c == 2'h3 || !sec) && (p == 2'h1 || p == 2'h2))
            sh = p;
        return {sh == 2'h2, sh == 2'h1, !sec && (c == 2'h3 || p == 2'h3)};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wait_hi(ref logic sig, input int lim);
        for (int i = 0; i < lim; i++)
        begin
            @(posedge ref_clk);
            if (sig === 1'h1)
                return;
        end
        bad_count++;
        close_out();
    endtask
    // one word started just after a period start, decoded mid-period
    task automatic word(input logic sec, input logic [1:0] c, input logic [1:0] p);
        logic [15:0] tx;
        logic [15:0] rx;
        logic [13:0] adc;
        logic [2:0] ex;
        tx = sec ? {c, 14'($urandom)} : {14'($urandom), c};
        adc = 14'($urandom);
        ex = expect_req(sec, c, p);
        wait_hi(sample_strobe, 600);
        check(16'({phase_earlier, phase_later}), 16'(prev_ph));
        hw_request_pin_hi <= p[1];
        hw_request_pin_lo <= p[0];
        adc_sample <= adc;
        host_port_model_i.xfer(tx, rx);
        if (sec)
        begin
            wait_hi(ctrl_valid, 80);
            check(ctrl_word, tx);
            check(16'(reg_addr), 16'(tx[12:8]));
            check(rx, tx[13] ? {8'h0, rd_model(tx[12:8])} : 16'h0);
        end
        else
        begin
            wait_hi(dac_valid, 80);
            check(16'(dac_data), 16'(tx[15:2]));
            check(rx, {adc, 2'h0});
        end
        repeat (2) @(posedge ref_clk);
        check(16'(secondary_pending), 16'(ex[0]));
        prev_ph = ex[2:1];
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        logic [1:0] c;
        logic [1:0] p;
        void'($urandom(32'h8B93925F));
        a_prime <= 8'($urandom_range(32'h28)) - 8'h14;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'h1;
        repeat (8) @(posedge ref_clk);
        for (int k = 0; k < 48; k++)
        begin
            c = (k < 16) ? 2'(k >> 2) : (k < 32) ? 2'h3 : 2'($urandom);
            p = (k < 16) ? 2'(k) : 2'($urandom);
            word(1'h0, c, p);
            if (c == 2'h3 || p == 2'h3)
            begin
                c = (k >= 16 && k < 32) ? 2'(k) : 2'($urandom);
                p = (k >= 16 && k < 32) ? 2'(k >> 2) : 2'($urandom);
                word(1'h1, c, p);
            end
        end
        wait_hi(sample_strobe, 600);
        check(16'({phase_earlier, phase_later}), 16'(prev_ph));
        // master mode: pins ask a secondary in every period
        master_mode <= 1'h1;
        hw_request_pin_hi <= 1'h1;
        hw_request_pin_lo <= 1'h1;
        repeat (3)
        begin
            wait_hi(ctrl_valid, 800);
            repeat (2) @(posedge ref_clk);
            check(16'(secondary_pending), 16'h0);
        end
        close_out();
    end
endmodule
bind codec_serial_request_decoder codec_request_checker #(.SCLK_HALF(SCLK_HALF))
    codec_request_checker_i
(
    .ref_clk, .rst_n, .master_mode, .a_div, .b_div, .a_prime, .frame_sync_out_n, .dac_valid,
    .shift_clk_out, .ctrl_valid, .sample_strobe, .phase_earlier, .phase_later, .secondary_pending
);
